// >>> hw/tdm_hwy_defs.vh
`ifndef TDM_HWY_DEFS_VH
`define TDM_HWY_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HWY_MCLK_PERIOD_NS  5
// Half period of the fastest bit clock (4.096 MHz)
`define HWY_MIN_HALF_NS     122
`define HWY_MIN_HALF_CYC    ((`HWY_MIN_HALF_NS + `HWY_MCLK_PERIOD_NS - 1) / `HWY_MCLK_PERIOD_NS)
`define HWY_SYNC_STAGES     2

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define HWY_POS_W           10
`define HWY_POS_FIRST       10'h001
`define HWY_POS_MAX         10'h3FF
// Offsets of sub-frame fields from the sub-frame base (32 bits each)
`define HWY_MON_OFS         10'h011
`define HWY_CI6_OFS         10'h019
`define HWY_CI4_OFS         10'h01B
`define HWY_MON_LEN         10'h008
`define HWY_CI6_LEN         10'h006
`define HWY_CI4_LEN         10'h004
`define HWY_AUD_W           32
`define HWY_BYTE_ONES       8'hFF

`endif

// >>> hw/hwy_two_slot_buf.v
`timescale 1ns/1ps

module hwy_two_slot_buf #(
  parameter WIDTH = 8
) (
  input  wire             mclk_i,     // System clock
  input  wire             rst_n_i,    // Sync reset, active low
  input  wire [WIDTH-1:0] in_data_i,  // Write data
  input  wire             in_valid_i, // Write request
  output wire             in_ready_o, // Room for a word
  output wire [WIDTH-1:0] out_data_o, // Head word
  output wire             out_valid_o,// Head word present
  input  wire             out_ready_i // Reader takes head
);

  reg [WIDTH-1:0] head_reg;
  reg [WIDTH-1:0] tail_reg;
  reg             head_v_reg;
  reg             tail_v_reg;
  wire            push;
  wire            pop;

  assign push        = in_valid_i & ~tail_v_reg;
  assign pop         = head_v_reg & out_ready_i;
  assign in_ready_o  = ~tail_v_reg;
  assign out_data_o  = head_reg;
  assign out_valid_o = head_v_reg;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      head_reg   <= {WIDTH{1'b0}};
      tail_reg   <= {WIDTH{1'b0}};
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
    end else if (pop) begin
      if (tail_v_reg) begin
        head_reg   <= tail_reg;
        tail_v_reg <= 1'b0;
      end else begin
        head_v_reg <= push;
        head_reg   <= in_data_i;
      end
    end else if (push) begin
      if (!head_v_reg) begin
        head_v_reg <= 1'b1;
        head_reg   <= in_data_i;
      end else begin
        tail_v_reg <= 1'b1;
        tail_reg   <= in_data_i;
      end
    end
  end

endmodule // hwy_two_slot_buf

// >>> hw/tdm_highway_port.v
`timescale 1ns/1ps
`include "tdm_hwy_defs.vh"

// How it works
// - Each data line is open drain or push-pull, chosen per line.
// - Bit clock and frame sync are each either input or output.
// - Bit clock is twice the bit rate unless single rate selected.
// - Bit rate 16 kbit/s to 4.096 Mbit/s; clock follows accordingly.
// - Slot count never set; each 8 kHz frame sync starts a frame.
// - Bits launched on rising clock edges, sampled on falling edges.
// - First frame bit is driven after the frame sync rising edge.
// - Single rate samples first falling edge; double rate the second.
// - Audio channels: any line, start 1 to 512, length 1 to 32.
// - Data channels: programmable start, length 1 to 256 bits.
// - Monitor in third byte of sub-frame 0 to 15, lines swappable.
// - C/I channels 4 or 6 bits in fourth byte, direction selectable.
// - Sample interrupt once per frame from frame sync.
// - Channel registers double-buffered against overflow and underflow.
// - Alternative interrupt after a set count of 1 to 32 bits.
// - Data lines undriven outside own transmit slots.
module tdm_highway_port (
  input  wire        mclk_i,                  // System clock
  input  wire        rst_n_i,                 // Sync reset, active low
  input  wire        highway_bit_clock_i,     // Bit clock pin in
  output wire        highway_bit_clock_o,     // Bit clock pin out
  output wire        highway_bit_clock_oe_o,  // Bit clock drive enable
  input  wire        highway_frame_sync_i,    // Frame sync pin in
  output wire        highway_frame_sync_o,    // Frame sync pin out
  output wire        highway_frame_sync_oe_o, // Frame sync drive enable
  input  wire        line_a_data_i,           // Line A pin in
  output wire        line_a_data_o,           // Line A pin out
  output wire        line_a_data_oe_o,        // Line A drive enable
  input  wire        line_b_data_i,           // Line B pin in
  output wire        line_b_data_o,           // Line B pin out
  output wire        line_b_data_oe_o,        // Line B drive enable
  input  wire        clk_out_en_i,            // Drive bit clock
  input  wire        fs_out_en_i,             // Drive frame sync
  input  wire        clock_rate_select_i,     // 1 single, 0 double rate
  input  wire [1:0]  open_drain_i,            // Per line: 1 open drain
  input  wire [12:0] clk_half_i,              // Generated half period, mclk
  input  wire [9:0]  frame_bits_i,            // Generated frame length, bits
  input  wire        arx_line_i,              // Audio rx: 0 A, 1 B
  input  wire [9:0]  arx_start_i,             // Audio rx start bit
  input  wire [5:0]  arx_len_i,               // Audio rx length
  input  wire        atx_line_i,              // Audio tx: 0 A, 1 B
  input  wire [9:0]  atx_start_i,             // Audio tx start bit
  input  wire [5:0]  atx_len_i,               // Audio tx length
  input  wire        drx_line_i,              // Data rx line
  input  wire [9:0]  drx_start_i,             // Data rx start bit
  input  wire [8:0]  drx_len_i,               // Data rx length
  input  wire        dtx_line_i,              // Data tx line
  input  wire [9:0]  dtx_start_i,             // Data tx start bit
  input  wire [8:0]  dtx_len_i,               // Data tx length
  input  wire [3:0]  mon_sub_i,               // Monitor sub-frame
  input  wire        mon_dir_i,               // 0: in A out B, 1: swapped
  input  wire [3:0]  ci_sub_i,                // C/I sub-frame
  input  wire        ci_dir_i,                // 0: in A out B, 1: swapped
  input  wire        ci_wide_i,               // 1: 6-bit C/I, 0: 4-bit
  input  wire        irq_count_mode_i,        // 1: interrupt per bit count
  input  wire [5:0]  irq_bits_i,              // Bit count 1 to 32
  input  wire [31:0] atx_data_i,              // Audio tx sample
  input  wire        atx_we_i,                // Audio tx write strobe
  input  wire [7:0]  mon_tx_i,                // Monitor byte to send
  input  wire [5:0]  ci_tx_i,                 // C/I code to send
  input  wire [7:0]  dtx_data_i,              // Data tx byte
  input  wire        dtx_valid_i,             // Data tx byte offered
  output wire        dtx_ready_o,             // Data tx byte accepted
  output wire [7:0]  drx_data_o,              // Data rx byte
  output wire        drx_valid_o,             // Data rx byte present
  input  wire        drx_ready_i,             // Data rx byte taken
  output reg         drx_lost_o,              // Data rx byte dropped, pulse
  output reg  [31:0] arx_data_o,              // Audio rx sample
  output reg  [7:0]  mon_rx_o,                // Monitor byte received
  output reg  [5:0]  ci_rx_o,                 // C/I code received
  output reg         sample_irq_o             // Sample transfer, pulse
);

  localparam [12:0] MIN_HALF = `HWY_MIN_HALF_CYC;

  function in_win;
    input [9:0] pos;
    input [9:0] start;
    input [9:0] len;
    begin
      in_win = (pos >= start) && ({1'b0, pos} < ({1'b0, start} + {1'b0, len}));
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  reg [1:0]  clk_sync_reg;
  reg [1:0]  fs_sync_reg;
  reg [1:0]  a_sync_reg;
  reg [1:0]  b_sync_reg;
  reg        clk_last_reg;
  reg        fs_at_rise_reg;
  reg        clk_gen_reg;
  reg        fs_gen_reg;
  reg        clk_oe_reg;
  reg        fs_oe_reg;
  reg [12:0] div_cnt_reg;
  reg [10:0] fs_cnt_reg;
  wire       clk_now;
  wire       fs_now;
  wire       rise;
  wire       fall;
  wire [12:0] half;
  wire [10:0] fs_period;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      clk_sync_reg <= 2'h0;
      fs_sync_reg  <= 2'h0;
      a_sync_reg   <= 2'h3;
      b_sync_reg   <= 2'h3;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], highway_bit_clock_i};
      fs_sync_reg  <= {fs_sync_reg[0], highway_frame_sync_i};
      a_sync_reg   <= {a_sync_reg[0], line_a_data_i};
      b_sync_reg   <= {b_sync_reg[0], line_b_data_i};
    end
  end

  assign clk_now = clk_oe_reg ? clk_gen_reg : clk_sync_reg[1];
  assign fs_now  = fs_oe_reg ? fs_gen_reg : fs_sync_reg[1];
  assign rise    = clk_now & ~clk_last_reg;
  assign fall    = ~clk_now & clk_last_reg;

  // ----------------------------------------------------------------
  // Bit clock and frame sync generators
  // ----------------------------------------------------------------
  // clamp to fastest rate
  assign half      = (clk_half_i < MIN_HALF) ? MIN_HALF : clk_half_i;
  // two clocks per bit in double rate
  assign fs_period = clock_rate_select_i ? {1'b0, frame_bits_i} : {frame_bits_i, 1'b0};

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      clk_oe_reg     <= 1'b0;
      fs_oe_reg      <= 1'b0;
      clk_gen_reg    <= 1'b0;
      fs_gen_reg     <= 1'b0;
      div_cnt_reg    <= 13'h0000;
      fs_cnt_reg     <= 11'h000;
      clk_last_reg   <= 1'b0;
      fs_at_rise_reg <= 1'b0;
    end else begin
      clk_oe_reg   <= clk_out_en_i;
      fs_oe_reg    <= fs_out_en_i;
      clk_last_reg <= clk_now;
      if (div_cnt_reg >= half - 13'h0001) begin
        div_cnt_reg <= 13'h0000;
        clk_gen_reg <= ~clk_gen_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + 13'h0001;
      end
      if (rise) begin
        fs_at_rise_reg <= fs_now;
        // one sync pulse per frame, one clock wide
        if (fs_cnt_reg >= fs_period - 11'h001) begin
          fs_cnt_reg <= 11'h000;
          fs_gen_reg <= 1'b1;
        end else begin
          fs_cnt_reg <= fs_cnt_reg + 11'h001;
          fs_gen_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Bit position tracking
  // ----------------------------------------------------------------
  reg        act_reg;
  reg        ph_reg;
  reg [9:0]  pos_reg;
  wire       dbl;
  wire       fstart;
  wire       adv;
  wire       launch;
  wire       smp;
  wire [9:0] pos_n;

  assign dbl    = ~clock_rate_select_i;
  // frame begins at first rise with sync high
  assign fstart = rise & fs_now & ~fs_at_rise_reg;
  assign adv    = rise & act_reg & (~dbl | ph_reg) & ~fstart;
  assign launch = fstart | adv;
  // double rate samples at three quarters
  assign smp    = fall & act_reg & (~dbl | ph_reg);
  // count from 1, saturate until next sync
  assign pos_n  = fstart ? `HWY_POS_FIRST :
                  (adv && pos_reg != `HWY_POS_MAX) ? pos_reg + 10'h001 : pos_reg;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      act_reg <= 1'b0;
      ph_reg  <= 1'b0;
      pos_reg <= 10'h000;
    end else if (rise) begin
      pos_reg <= pos_n;
      if (fstart) begin
        act_reg <= 1'b1;
        ph_reg  <= 1'b0;
      end else begin
        ph_reg <= dbl & ~ph_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Slot windows
  // ----------------------------------------------------------------
  wire [9:0] mon_base;
  wire [9:0] ci_base;
  wire [9:0] ci_len;
  wire [9:0] ci_ofs;
  wire       atx_w;
  wire       dtx_w;
  wire       mtx_w;
  wire       ctx_w;
  wire       arx_w;
  wire       drx_w;
  wire       mrx_w;
  wire       crx_w;

  assign mon_base = {1'b0, mon_sub_i, 5'h00} + `HWY_MON_OFS;
  assign ci_ofs   = ci_wide_i ? `HWY_CI6_OFS : `HWY_CI4_OFS;
  assign ci_len   = ci_wide_i ? `HWY_CI6_LEN : `HWY_CI4_LEN;
  assign ci_base  = {1'b0, ci_sub_i, 5'h00} + ci_ofs;
  assign atx_w = in_win(pos_n, atx_start_i, {4'h0, atx_len_i});
  assign dtx_w = in_win(pos_n, dtx_start_i, {1'b0, dtx_len_i});
  assign mtx_w = in_win(pos_n, mon_base, `HWY_MON_LEN);
  assign ctx_w = in_win(pos_n, ci_base, ci_len);
  assign arx_w = in_win(pos_reg, arx_start_i, {4'h0, arx_len_i});
  assign drx_w = in_win(pos_reg, drx_start_i, {1'b0, drx_len_i});
  assign mrx_w = in_win(pos_reg, mon_base, `HWY_MON_LEN);
  assign crx_w = in_win(pos_reg, ci_base, ci_len);

  // ----------------------------------------------------------------
  // Transmit shifters
  // ----------------------------------------------------------------
  reg [31:0] atx_hold_reg;
  reg [31:0] atx_sh_reg;
  reg [7:0]  mon_sh_reg;
  reg [5:0]  ci_sh_reg;
  reg [7:0]  dtx_sh_reg;
  reg [2:0]  dtx_cnt_reg;
  reg [7:0]  dtx_byte_reg;
  reg        dtx_have_reg;
  reg        dtx_ready_reg;
  reg [1:0]  ln_out_reg;
  reg [1:0]  ln_oe_reg;
  reg [5:0]  bit_cnt_reg;
  wire [2:0] dtx_cnt_eff;
  wire       dtx_bit;
  wire       dtx_take;
  wire       dtx_have_next;
  wire       hit;
  wire       xfer;
  wire       ra;
  wire       rb;
  wire [1:0] drv;
  wire [1:0] dbit;
  wire [31:0] atx_load;
  wire [31:0] atx_cur;

  assign ra            = a_sync_reg[1];
  assign rb            = b_sync_reg[1];
  assign dtx_cnt_eff   = fstart ? 3'h0 : dtx_cnt_reg;
  assign dtx_bit       = (dtx_cnt_eff == 3'h0) ? (dtx_have_reg ? dtx_byte_reg[7] : 1'b1) : dtx_sh_reg[7];
  assign dtx_take      = launch & dtx_w & (dtx_cnt_eff == 3'h0);
  assign dtx_have_next = (dtx_have_reg & ~dtx_take) | (dtx_valid_i & dtx_ready_reg);
  assign dtx_ready_o   = dtx_ready_reg;
  // bit-count event on audio rx bits
  assign hit           = irq_count_mode_i & smp & arx_w & (bit_cnt_reg + 6'h01 >= irq_bits_i);
  assign xfer          = irq_count_mode_i ? hit : fstart;
  assign atx_load      = atx_hold_reg << (6'd32 - atx_len_i);
  assign atx_cur       = xfer ? atx_load : atx_sh_reg;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_line
      wire ln;
      assign ln = (gi == 1);
      assign drv[gi]  = (atx_w & (atx_line_i == ln)) | (dtx_w & (dtx_line_i == ln)) |
                        (mtx_w & (mon_dir_i != ln)) | (ctx_w & (ci_dir_i != ln));
      assign dbit[gi] = (atx_w & (atx_line_i == ln)) ? atx_cur[31] :
                        (dtx_w & (dtx_line_i == ln)) ? dtx_bit :
                        (mtx_w & (mon_dir_i != ln)) ? mon_sh_reg[7] : ci_sh_reg[5];
      always @(posedge mclk_i) begin
        if (!rst_n_i) begin
          ln_out_reg[gi] <= 1'b1;
          ln_oe_reg[gi]  <= 1'b0;
        end else if (launch) begin
          ln_out_reg[gi] <= open_drain_i[gi] ? 1'b0 : dbit[gi];
          ln_oe_reg[gi]  <= drv[gi] & (~open_drain_i[gi] | ~dbit[gi]);
        end else if (fstart | ~act_reg) begin
          ln_oe_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      atx_hold_reg  <= 32'h00000000;
      atx_sh_reg    <= 32'h00000000;
      mon_sh_reg    <= `HWY_BYTE_ONES;
      ci_sh_reg     <= 6'h3F;
      dtx_sh_reg    <= `HWY_BYTE_ONES;
      dtx_cnt_reg   <= 3'h0;
      dtx_byte_reg  <= 8'h00;
      dtx_have_reg  <= 1'b0;
      dtx_ready_reg <= 1'b0;
    end else begin
      // write side of audio tx buffer
      if (atx_we_i)
        atx_hold_reg <= atx_data_i;
      if (dtx_valid_i & dtx_ready_reg)
        dtx_byte_reg <= dtx_data_i;
      dtx_have_reg  <= dtx_have_next;
      dtx_ready_reg <= ~dtx_have_next;
      // swap in new sample, MSB first
      if (launch & atx_w)
        atx_sh_reg <= {atx_cur[30:0], 1'b0};
      else if (xfer)
        atx_sh_reg <= atx_load;
      if (fstart) begin
        mon_sh_reg <= mon_tx_i;
        ci_sh_reg  <= ci_wide_i ? ci_tx_i : {ci_tx_i[3:0], 2'h0};
      end else begin
        if (launch & mtx_w)
          mon_sh_reg <= {mon_sh_reg[6:0], 1'b1};
        if (launch & ctx_w)
          ci_sh_reg <= {ci_sh_reg[4:0], 1'b1};
      end
      if (launch & dtx_w) begin
        dtx_cnt_reg <= dtx_cnt_eff + 3'h1;
        if (dtx_take)
          dtx_sh_reg <= (dtx_have_reg ? dtx_byte_reg : `HWY_BYTE_ONES) << 1;
        else
          dtx_sh_reg <= {dtx_sh_reg[6:0], 1'b1};
      end else if (fstart) begin
        dtx_cnt_reg <= 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive shifters
  // ----------------------------------------------------------------
  reg [31:0] arx_sh_reg;
  reg [7:0]  mon_in_reg;
  reg [5:0]  ci_in_reg;
  reg [7:0]  drx_sh_reg;
  reg [2:0]  drx_cnt_reg;
  reg [7:0]  push_data_reg;
  reg        push_reg;
  wire       arx_bit;
  wire       drx_bit;
  wire       mc_bit_m;
  wire       mc_bit_c;
  wire       buf_ready;

  assign arx_bit  = arx_line_i ? rb : ra;
  assign drx_bit  = drx_line_i ? rb : ra;
  assign mc_bit_m = mon_dir_i ? rb : ra;
  assign mc_bit_c = ci_dir_i ? rb : ra;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      arx_sh_reg    <= 32'h00000000;
      arx_data_o    <= 32'h00000000;
      mon_in_reg    <= 8'h00;
      ci_in_reg     <= 6'h00;
      mon_rx_o      <= 8'hFF;
      ci_rx_o       <= 6'h3F;
      drx_sh_reg    <= 8'h00;
      drx_cnt_reg   <= 3'h0;
      push_data_reg <= 8'h00;
      push_reg      <= 1'b0;
      drx_lost_o    <= 1'b0;
      bit_cnt_reg   <= 6'h00;
      sample_irq_o  <= 1'b0;
    end else begin
      sample_irq_o <= xfer;
      // read side of audio rx buffer
      if (hit) begin
        arx_data_o  <= {arx_sh_reg[30:0], arx_bit};
        arx_sh_reg  <= 32'h00000000;
        bit_cnt_reg <= 6'h00;
      end else if (xfer) begin
        arx_data_o <= arx_sh_reg;
        arx_sh_reg <= 32'h00000000;
      end else if (smp & arx_w) begin
        arx_sh_reg <= {arx_sh_reg[30:0], arx_bit};
        if (irq_count_mode_i)
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
      if (fstart) begin
        mon_rx_o <= mon_in_reg;
        ci_rx_o  <= ci_in_reg;
      end else begin
        if (smp & mrx_w)
          mon_in_reg <= {mon_in_reg[6:0], mc_bit_m};
        if (smp & crx_w)
          ci_in_reg <= {ci_in_reg[4:0], mc_bit_c};
      end
      // bytes of data rx into buffer
      push_reg   <= 1'b0;
      drx_lost_o <= push_reg & ~buf_ready;
      if (fstart) begin
        drx_cnt_reg <= 3'h0;
      end else if (smp & drx_w) begin
        drx_sh_reg  <= {drx_sh_reg[6:0], drx_bit};
        drx_cnt_reg <= drx_cnt_reg + 3'h1;
        if (drx_cnt_reg == 3'h7) begin
          push_reg      <= 1'b1;
          push_data_reg <= {drx_sh_reg[6:0], drx_bit};
        end
      end
    end
  end

  hwy_two_slot_buf #(
    .WIDTH (8)
  ) u_rx_buf (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   (push_data_reg),
    .in_valid_i  (push_reg),
    .in_ready_o  (buf_ready),
    .out_data_o  (drx_data_o),
    .out_valid_o (drx_valid_o),
    .out_ready_i (drx_ready_i)
  );

  assign highway_bit_clock_o     = clk_gen_reg;
  assign highway_bit_clock_oe_o  = clk_oe_reg;
  assign highway_frame_sync_o    = fs_gen_reg;
  assign highway_frame_sync_oe_o = fs_oe_reg;
  assign line_a_data_o           = ln_out_reg[0];
  assign line_a_data_oe_o        = ln_oe_reg[0];
  assign line_b_data_o           = ln_out_reg[1];
  assign line_b_data_oe_o        = ln_oe_reg[1];

endmodule // tdm_highway_port

// >>> verification/hwy_far_end.sv
`timescale 1ns/1ps

module hwy_far_end #(
  parameter int FL = 40
) (
  output logic        bclk_o, // Bit clock to device
  output logic        fs_o,   // Frame sync to device
  output logic        a_o,    // Line A value
  output logic        a_oe_o, // Line A driven
  input  wire logic   b_i,    // Line B level
  input  wire [63:0]  pat_i,  // Line A frame, bit 1 at MSB
  output logic [63:0] cap_o   // Line B frame, bit 1 at MSB
);
  int pos = 0;

  initial begin
    bclk_o = 1'b0;
    fs_o = 1'b0;
    a_o = 1'b1;
    a_oe_o = 1'b0;
    cap_o = '1;
  end

  always #32 bclk_o = ~bclk_o;

  always @(negedge bclk_o) begin
    fs_o <= (pos == FL);
    if (pos > 0) cap_o[64-pos] <= b_i;
  end

  always @(posedge bclk_o) begin
    pos = fs_o ? 1 : pos + 1;
    a_o <= pat_i[64-pos];
    a_oe_o <= 1'b1;
  end
endmodule // hwy_far_end

// >>> verification/tdm_highway_port_sva.sv
`timescale 1ns/1ps

module tdm_hwy_chk (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       clk_out_en_i,
  input wire logic       fs_out_en_i,
  input wire logic       highway_bit_clock_oe_o,
  input wire logic       highway_frame_sync_oe_o,
  input wire logic [1:0] open_drain_i,
  input wire logic       line_a_data_o,
  input wire logic       line_a_data_oe_o,
  input wire logic       line_b_data_o,
  input wire logic       line_b_data_oe_o,
  input wire logic       sample_irq_o,
  input wire logic       drx_lost_o,
  input wire logic       drx_valid_o,
  input wire logic       drx_ready_i,
  input wire logic [7:0] drx_data_o,
  input wire logic       dtx_valid_i,
  input wire logic       dtx_ready_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_od_line_a: assert property (line_a_data_oe_o && $past(open_drain_i[0]) |-> !line_a_data_o)
    else $error("line A high while open drain");
  a_od_line_b: assert property (line_b_data_oe_o && $past(open_drain_i[1]) |-> !line_b_data_o)
    else $error("line B high while open drain");
  a_clk_drive: assert property (1'b1 |=> highway_bit_clock_oe_o == $past(clk_out_en_i))
    else $error("bit clock enable wrong");
  a_fs_drive: assert property (1'b1 |=> highway_frame_sync_oe_o == $past(fs_out_en_i))
    else $error("frame sync enable wrong");
  a_irq_single: assert property ($rose(sample_irq_o) |=> !sample_irq_o [*4])
    else $error("sample event too long");
  a_lost_pulse: assert property (drx_lost_o |=> !drx_lost_o)
    else $error("lost flag too long");
  a_drx_hold: assert property (drx_valid_o && !drx_ready_i |=> drx_valid_o && $stable(drx_data_o))
    else $error("rx byte not held");
  a_dtx_take: assert property (dtx_valid_i && dtx_ready_o |=> !dtx_ready_o)
    else $error("tx ready stayed high");

  c_irq: cover property (sample_irq_o);
  c_lost: cover property (drx_lost_o);
  c_take: cover property (dtx_valid_i && dtx_ready_o);
endmodule // tdm_hwy_chk

bind tdm_highway_port tdm_hwy_chk i_chk (.*);

// >>> verification/tb.sv
`timescale 1ns/1ps

module tb;
  logic        mclk_i, rst_n_i, clk_out_en_i, fs_out_en_i, clock_rate_select_i, arx_line_i, atx_line_i;
  logic        drx_line_i, dtx_line_i, mon_dir_i, ci_dir_i, ci_wide_i, irq_count_mode_i, atx_we_i;
  logic        dtx_valid_i, drx_ready_i, lost_seen;
  logic [1:0]  open_drain_i;
  logic [12:0] clk_half_i;
  logic [9:0]  frame_bits_i, arx_start_i, atx_start_i, drx_start_i, dtx_start_i;
  logic [5:0]  arx_len_i, atx_len_i, irq_bits_i, ci_tx_i;
  logic [8:0]  drx_len_i, dtx_len_i;
  logic [3:0]  mon_sub_i, ci_sub_i;
  logic [31:0] atx_data_i;
  logic [7:0]  mon_tx_i, dtx_data_i;
  logic [63:0] pat;
  wire  [63:0] cap;
  wire         highway_bit_clock_i, highway_frame_sync_i, line_a_data_i, line_b_data_i, fe_a, fe_a_oe;
  wire         highway_bit_clock_o, highway_bit_clock_oe_o, highway_frame_sync_o, highway_frame_sync_oe_o;
  wire         line_a_data_o, line_a_data_oe_o, line_b_data_o, line_b_data_oe_o;
  wire         dtx_ready_o, drx_valid_o, drx_lost_o, sample_irq_o;
  wire  [7:0]  drx_data_o, mon_rx_o;
  wire  [5:0]  ci_rx_o;
  wire  [31:0] arx_data_o;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          gap, fs_hi;

  tdm_highway_port i_dut (.*);
  hwy_far_end #(.FL(40)) i_far (.bclk_o(highway_bit_clock_i), .fs_o(highway_frame_sync_i), .a_o(fe_a),
    .a_oe_o(fe_a_oe), .b_i(line_b_data_i), .pat_i(pat), .cap_o(cap));

  // Both lines pulled up
  assign line_a_data_i = (line_a_data_oe_o ? line_a_data_o : 1'b1) & (fe_a_oe ? fe_a : 1'b1);
  assign line_b_data_i = line_b_data_oe_o ? line_b_data_o : 1'b1;

  always #2.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (drx_lost_o === 1'b1) lost_seen <= 1'b1;
  always @(posedge mclk_i) if (highway_frame_sync_o === 1'b1) fs_hi++;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wait_irq;
    gap = 0;
    do begin
      @(negedge mclk_i);
      gap++;
    end while (sample_irq_o !== 1'b1 && gap < 4000);
    if (gap >= 4000) chk(0, 1);
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task t_audio;
    atx_data_i = 32'h0000003C;
    atx_we_i = 1'b1;
    @(negedge mclk_i);
    atx_we_i = 1'b0;
    repeat (3) wait_irq;
    // 40 bits of 64 ns each
    chk(gap > 509 && gap < 515, 1);
    chk(arx_data_o, 32'h000000A5);
    chk(cap[61:54], 8'h3C);
    chk({cap[63:62], cap[53:52]}, 4'hF);
    open_drain_i = 2'h3;
    repeat (2) wait_irq;
    chk(cap[61:54], 8'h3C);
  endtask

  task t_count;
    irq_count_mode_i = 1'b1;
    for (int i = 0; i < 8 && arx_data_o !== 32'hA; i++) wait_irq;
    chk(arx_data_o, 32'h0000000A);
    wait_irq;
    chk(arx_data_o, 32'h00000005);
    chk(gap > 49 && gap < 54, 1);
    irq_count_mode_i = 1'b0;
  endtask

  task t_data;
    rst_n_i = 1'b0;
    repeat (10) @(negedge mclk_i);
    rst_n_i = 1'b1;
    lost_seen = 1'b0;
    dtx_valid_i = 1'b1;
    for (int i = 0; i < 20 && dtx_ready_o !== 1'b1; i++) @(negedge mclk_i);
    @(negedge mclk_i);
    dtx_valid_i = 1'b0;
    chk(dtx_ready_o, 0);
    repeat (2) wait_irq;
    chk(cap[51:44], 8'h5A);
    wait_irq;
    chk(cap[51:44], 8'hFF);
    chk(lost_seen, 1);
    chk({drx_valid_o, drx_data_o}, 9'h1C3);
    drx_ready_i = 1'b1;
    @(negedge mclk_i);
    chk({drx_valid_o, drx_data_o}, 9'h196);
    @(negedge mclk_i);
    drx_ready_i = 1'b0;
    chk(drx_valid_o, 0);
  endtask

  // Own clock and sync, double rate, clamped half period, audio looped on line B
  task t_gen;
    {clk_out_en_i, fs_out_en_i, clock_rate_select_i, arx_line_i} = 4'hD;
    {frame_bits_i, arx_start_i, clk_half_i} = {10'h010, 10'h003, 13'h0007};
    atx_data_i = 32'h0000003C;
    atx_we_i = 1'b1;
    @(negedge mclk_i);
    atx_we_i = 1'b0;
    repeat (3) wait_irq;
    fs_hi = 0;
    repeat (2) wait_irq;
    // 16 bits of two 50-cycle clocks each
    chk(gap, 1600);
    // Sync high one bit clock per frame
    chk(fs_hi, 100);
    chk(arx_data_o, 32'h0000003C);
  endtask

  initial begin
    {mclk_i, rst_n_i, clk_out_en_i, fs_out_en_i, arx_line_i, drx_line_i, mon_dir_i, ci_dir_i} = '0;
    {ci_wide_i, irq_count_mode_i, atx_we_i, dtx_valid_i, drx_ready_i, lost_seen} = '0;
    {clock_rate_select_i, atx_line_i, dtx_line_i} = 3'h7;
    {open_drain_i, clk_half_i, frame_bits_i} = {2'h0, 13'h0019, 10'h028};
    {arx_start_i, atx_start_i, drx_start_i, dtx_start_i} = {10'h005, 10'h003, 10'h00D, 10'h00D};
    {arx_len_i, atx_len_i, drx_len_i, dtx_len_i} = {6'h08, 6'h08, 9'h010, 9'h008};
    {mon_sub_i, ci_sub_i, irq_bits_i, ci_tx_i} = {8'hFF, 6'h04, 6'h2A};
    {atx_data_i, mon_tx_i, dtx_data_i} = {32'h0, 8'h5A, 8'h5A};
    pat = 64'h0A5C396000000000;
    repeat (10) @(negedge mclk_i);
    rst_n_i = 1'b1;
    t_audio;
    t_count;
    t_data;
    t_gen;
    end_sim;
  end

  initial begin
    #200000;
    n_fail++;
    end_sim;
  end
endmodule // tb
